/* File: design/acx_step_map.svh */
/*
 * Register map, field positions and reset values for the auxiliary
 * converter sequencer step three and step four configuration registers.
 * Assumes a 32-bit classic Wishbone slave; each register is one word.
 */
// How it works
// - Bit 15 of the step three register enables the step: one includes it, zero leaves it out.
// - Bits 14:13 pick the converter gain for step three: 00 gives 1, 01 gives 2, 10 and 11 give 4.
// - Bits 12:5 of the register are read-only and always read as zero.
// - Bit 4 routes the negative input: zero picks the analog ground, one picks external input seven.
// - Positive codes 0000 to 0111 connect external inputs zero to seven in order.
// - Positive codes 1000 to 1111 route an internal source and the negative input is chosen inside.
// - While the positive code is an internal one, the negative select bit has no effect.
// - The step four register sits at index 94h and resets to 0004h.
// - The step three register sits at index 93h and resets to 0003h, step disabled.
`ifndef ACX_STEP_MAP_SVH
`define ACX_STEP_MAP_SVH

`define ACX_IDX_STEP3     8'h93
`define ACX_IDX_STEP4     8'h94
`define ACX_ADR_STEP3     12'h24C
`define ACX_ADR_STEP4     12'h250
`define ACX_RST_STEP3     16'h0003
`define ACX_RST_STEP4     16'h0004
`define ACX_WR_MASK       16'hE01F
`define ACX_BIT_EN        15
`define ACX_GAIN_HI       14
`define ACX_GAIN_LO       13
`define ACX_RSV_HI        12
`define ACX_RSV_LO        5
`define ACX_BIT_NEG       4
`define ACX_POS_HI        3
`define ACX_POS_LO        0
`define ACX_BIT_POS_INT   3

`endif

/* File: design/acx_pkg.sv */
/*
 * Types shared by the step configuration decoder and the register block.
 * Assumes nothing of its surroundings.
 */
package acx_pkg;
    typedef enum logic [1:0] {
        ACX_NEG_GND,
        ACX_NEG_EXT7,
        ACX_NEG_AUTO
    } acx_neg_t;
endpackage : acx_pkg

/* File: design/acx_step_dec.sv */
/*
 * Combinational decode of one sequencer step configuration word into
 * converter gain, positive route and negative route.
 * Assumes the word already has its reserved bits cleared.
 */
`timescale 1ns/100ps
`default_nettype none
`include "acx_step_map.svh"
module acx_step_dec
    import acx_pkg::*;
(
    input  wire logic [15:0] cfg_i,
    output logic             enable_o,
    output logic [2:0]       gain_o,
    output logic [7:0]       pos_ext_o,
    output logic             pos_internal_o,
    output logic [2:0]       pos_int_o,
    output acx_neg_t         neg_mode_o
);
    logic [1:0] gain_code;
    logic [3:0] pos_code;

    always_comb begin
        gain_code      = cfg_i[`ACX_GAIN_HI:`ACX_GAIN_LO];
        pos_code       = cfg_i[`ACX_POS_HI:`ACX_POS_LO];
        enable_o       = cfg_i[`ACX_BIT_EN];
        // one-hot gain {x4, x2, x1}
        case (gain_code)
            2'h0:    gain_o = 3'h1;
            2'h1:    gain_o = 3'h2;
            default: gain_o = 3'h4;
        endcase
        pos_internal_o = pos_code[`ACX_BIT_POS_INT];
        pos_int_o      = pos_code[2:0];
        pos_ext_o      = 8'h00;
        if (!pos_internal_o) begin
            pos_ext_o[pos_code[2:0]] = 1'b1;
        end
        // internal sources override the negative select bit
        if (pos_internal_o) begin
            neg_mode_o = ACX_NEG_AUTO;
        end else if (cfg_i[`ACX_BIT_NEG]) begin
            neg_mode_o = ACX_NEG_EXT7;
        end else begin
            neg_mode_o = ACX_NEG_GND;
        end
    end
endmodule : acx_step_dec
`default_nettype wire

/* File: design/acx_step_regs.sv */
/*
 * Step three and step four configuration registers of the auxiliary
 * converter sequencer, behind a classic Wishbone slave, with the decoded
 * step three routing and the skip/convert answer to the sequencer.
 * Assumes one clock, a synchronous active-high reset, and a sequencer that
 * pulses seq_step_three_i for one cycle when it reaches step three.
 */
`timescale 1ns/100ps
`default_nettype none
`include "acx_step_map.svh"
module acx_step_regs
    import acx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        seq_step_three_i,
    output logic             step_three_convert_o,
    output logic             step_three_skip_o,
    output logic [2:0]       step_three_gain_o,
    output logic [7:0]       step_three_pos_ext_o,
    output logic             step_three_pos_internal_o,
    output logic [2:0]       step_three_pos_int_o,
    output acx_neg_t         step_three_neg_mode_o,
    output logic [15:0]      step_four_config_o
);
    logic [15:0] step3_r;
    logic [15:0] step3_nxt;
    logic [15:0] step4_r;
    logic [15:0] step4_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic        conv_r;
    logic        conv_nxt;
    logic        skip_r;
    logic        skip_nxt;
    logic [2:0]  gain_r;
    logic [7:0]  pos_ext_r;
    logic        pos_internal_r;
    logic [2:0]  pos_int_r;
    acx_neg_t    neg_mode_r;
    logic [2:0]  dec_gain;
    logic [7:0]  dec_pos_ext;
    logic        dec_pos_internal;
    logic [2:0]  dec_pos_int;
    acx_neg_t    dec_neg;
    logic        bus_req;
    logic        hit3;
    logic        hit4;
    logic [15:0] lane_mask;

    // decode from the next value so the routing outputs track the register
    acx_step_dec u_dec3 (
        .cfg_i          (step3_nxt),
        .enable_o       (),
        .gain_o         (dec_gain),
        .pos_ext_o      (dec_pos_ext),
        .pos_internal_o (dec_pos_internal),
        .pos_int_o      (dec_pos_int),
        .neg_mode_o     (dec_neg)
    );

    always_comb begin
        bus_req   = wb_cyc_i && wb_stb_i && !ack_r;
        hit3      = (wb_adr_i == `ACX_ADR_STEP3);
        hit4      = (wb_adr_i == `ACX_ADR_STEP4);
        lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `ACX_WR_MASK;
        step3_nxt = step3_r;
        step4_nxt = step4_r;
        rdat_nxt  = 32'h0000_0000;
        ack_nxt   = bus_req;
        if (bus_req && wb_we_i && hit3) begin
            step3_nxt = (step3_r & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
        end
        if (bus_req && wb_we_i && hit4) begin
            step4_nxt = (step4_r & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
        end
        // unmapped reads answer with zero, unmapped writes are dropped
        if (bus_req && !wb_we_i && hit3) begin
            rdat_nxt = {16'h0000, step3_r};
        end else if (bus_req && !wb_we_i && hit4) begin
            rdat_nxt = {16'h0000, step4_r};
        end
        // the sequencer sees the enable as it stands at its request
        conv_nxt  = seq_step_three_i && step3_r[`ACX_BIT_EN];
        skip_nxt  = seq_step_three_i && !step3_r[`ACX_BIT_EN];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step3_r        <= `ACX_RST_STEP3;
            step4_r        <= `ACX_RST_STEP4;
            ack_r          <= 1'b0;
            rdat_r         <= 32'h0000_0000;
            conv_r         <= 1'b0;
            skip_r         <= 1'b0;
            gain_r         <= 3'h1;
            pos_ext_r      <= 8'h08;
            pos_internal_r <= 1'b0;
            pos_int_r      <= 3'h3;
            neg_mode_r     <= ACX_NEG_GND;
        end else if (ce_i) begin
            step3_r        <= step3_nxt;
            step4_r        <= step4_nxt;
            ack_r          <= ack_nxt;
            rdat_r         <= rdat_nxt;
            conv_r         <= conv_nxt;
            skip_r         <= skip_nxt;
            gain_r         <= dec_gain;
            pos_ext_r      <= dec_pos_ext;
            pos_internal_r <= dec_pos_internal;
            pos_int_r      <= dec_pos_int;
            neg_mode_r     <= dec_neg;
        end
    end

    assign wb_ack_o                  = ack_r;
    assign wb_dat_o                  = rdat_r;
    assign step_three_convert_o      = conv_r;
    assign step_three_skip_o         = skip_r;
    assign step_three_gain_o         = gain_r;
    assign step_three_pos_ext_o      = pos_ext_r;
    assign step_three_pos_internal_o = pos_internal_r;
    assign step_three_pos_int_o      = pos_int_r;
    assign step_three_neg_mode_o     = neg_mode_r;
    assign step_four_config_o        = step4_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_step3_write: assert property (
        ce_i && bus_req && wb_we_i && hit3 && (wb_sel_i[1:0] == 2'h3)
        |=> step3_r == ($past(wb_dat_i[15:0]) & `ACX_WR_MASK)
    ) else $error("step three write not stored");

    a_step4_write: assert property (
        ce_i && bus_req && wb_we_i && hit4 && (wb_sel_i[1:0] == 2'h3)
        |=> step4_r == ($past(wb_dat_i[15:0]) & `ACX_WR_MASK)
    ) else $error("step four write not stored");

    a_rsv_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[12:5] == 8'h00
    ) else $error("reserved bits read non-zero");

    a_rsv_store: assert property (
        step3_r[12:5] == 8'h00 && step4_r[12:5] == 8'h00
    ) else $error("reserved bits held non-zero");

    a_ack_once: assert property (
        ce_i && wb_ack_o |=> !wb_ack_o
    ) else $error("ack held for two cycles");

    // a low enable must hold both step registers and the ack, pulses included
    a_freeze_state: assert property (
        !ce_i |=> $stable(step3_r) && $stable(step4_r) && $stable(wb_ack_o)
            && $stable(step_three_convert_o) && $stable(step_three_skip_o)
    ) else $error("state changed while clock enable low");

    a_ack_timing: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o
    ) else $error("ack not given one cycle after request");

    a_skip_dis: assert property (
        ce_i && seq_step_three_i && !step3_r[15] |=> step_three_skip_o && !step_three_convert_o
    ) else $error("disabled step three not skipped");

    a_conv_en: assert property (
        ce_i && seq_step_three_i && step3_r[15] |=> step_three_convert_o && !step_three_skip_o
    ) else $error("enabled step three not converted");

    a_gain_four: assert property (
        ce_i && step3_nxt[14] |=> step_three_gain_o == 3'h4
    ) else $error("gain code 1x not mapped to four");

    a_gain_two: assert property (
        ce_i && step3_nxt[14:13] == 2'h1 |=> step_three_gain_o == 3'h2
    ) else $error("gain code 01 not mapped to two");

    a_gain_one: assert property (
        ce_i && step3_nxt[14:13] == 2'h0 |=> step_three_gain_o == 3'h1
    ) else $error("gain code 00 not mapped to one");

    a_pos_int: assert property (
        ce_i && step3_nxt[3] |=> step_three_pos_internal_o
            && step_three_pos_int_o == $past(step3_nxt[2:0])
    ) else $error("internal source code not routed");

    a_neg_auto: assert property (
        ce_i && step3_nxt[3] |=> step_three_neg_mode_o == ACX_NEG_AUTO && step_three_pos_ext_o == 8'h00
    ) else $error("internal source did not force negative select");

    a_pos_ext: assert property (
        ce_i && !step3_nxt[3] |=> step_three_pos_ext_o == (8'h01 << $past(step3_nxt[2:0]))
    ) else $error("external input not routed in order");

    a_neg_ext7: assert property (
        ce_i && !step3_nxt[3] && step3_nxt[4] |=> step_three_neg_mode_o == ACX_NEG_EXT7
    ) else $error("negative select not routed to input seven");

    a_neg_gnd: assert property (
        ce_i && !step3_nxt[3] && !step3_nxt[4] |=> step_three_neg_mode_o == ACX_NEG_GND
    ) else $error("negative select not routed to ground");

    a_unmapped_rd: assert property (
        ce_i && bus_req && !wb_we_i && !hit3 && !hit4 |=> wb_dat_o == 32'h0000_0000
    ) else $error("unmapped read not zero");

    c_write3: cover property (ce_i && bus_req && wb_we_i && hit3);
    c_read4: cover property (ce_i && bus_req && !wb_we_i && hit4);
    c_skip: cover property (step_three_skip_o);
    c_auto: cover property (step_three_neg_mode_o == ACX_NEG_AUTO);
    c_freeze: cover property (!ce_i && seq_step_three_i);
endmodule : acx_step_regs
`default_nettype wire

/* File: testbench/acx_step_regs_tb.sv */
/*
 * Bench for the step three and four registers over classic Wishbone.
 * Assumes a registered ack one cycle after the request is taken.
 */
`timescale 1ns/100ps
`default_nettype none
`include "acx_step_map.svh"
module acx_step_regs_tb
    import acx_pkg::*;
();
    logic        clk_i, rst_i, ce_i, we, cyc, stb, ack, seq, conv, skip, pos_in;
    logic [2:0]  gain, pos_int;
    logic [3:0]  sel;
    logic [7:0]  pos_ext;
    logic [11:0] adr;
    logic [15:0] step4;
    logic [31:0] wdat, rdat;
    acx_neg_t    neg;
    int          error_cnt, tests_run;

    acx_step_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .seq_step_three_i(seq),
        .step_three_convert_o(conv), .step_three_skip_o(skip), .step_three_gain_o(gain),
        .step_three_pos_ext_o(pos_ext), .step_three_pos_internal_o(pos_in),
        .step_three_pos_int_o(pos_int), .step_three_neg_mode_o(neg),
        .step_four_config_o(step4));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // holds the request until ack is seen
    task automatic wb(input logic [11:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {adr, we, sel, wdat, cyc, stb} <= {a, w, s, d, 2'b11};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n == 20) begin
            error_cnt++;
            $display("[FAIL] wb ack expected 1 seen timeout");
            stop_test();
        end
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [3:0] s, input logic [15:0] d);
        logic [31:0] q;
        wb(a, 1'b1, s, {16'h0000, d}, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 4'hF, 32'h0000_0000, q);
        chk("read data", {16'h0000, e}, q);
    endtask : rd

    // expected values from the field encodings
    task automatic chk_route(input logic [15:0] c);
        logic [2:0] g;
        g = c[14] ? 3'h4 : (c[13] ? 3'h2 : 3'h1);
        chk("gain", 32'(g), 32'(gain));
        chk("pos_ext", 32'(c[3] ? 8'h00 : 8'h01 << c[2:0]), 32'(pos_ext));
        chk("pos_internal", 32'(c[3]), 32'(pos_in));
        chk("pos_int", 32'(c[2:0]), 32'(pos_int));
        chk("neg_mode", c[3] ? 32'(ACX_NEG_AUTO) : 32'(c[4]), 32'(neg));
    endtask : chk_route

    // f low freezes the block across the pulse
    task automatic seq_chk(input logic f, input logic en);
        @(posedge clk_i);
        {ce_i, seq} <= {f, 1'b1};
        @(posedge clk_i);
        seq <= 1'b0;
        @(posedge clk_i);
        ce_i <= 1'b1;
        chk("convert", 32'(f && en), 32'(conv));
        chk("skip", 32'(f && !en), 32'(skip));
    endtask : seq_chk

    initial begin
        logic [15:0] c;
        error_cnt = 0;
        tests_run = 0;
        {adr, wdat, we, sel, cyc, stb, seq} = '0;
        ce_i = 1'b1;
        // the second pass resets in mid-run
        for (int r = 0; r < 2; r++) begin
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            rd(`ACX_ADR_STEP3, 16'h0003);
            rd(`ACX_ADR_STEP4, 16'h0004);
            chk_route(16'h0003);
            seq_chk(1'b0, 1'b0);
            seq_chk(1'b1, 1'b0);
            $display("test reset and clock enable done");
            wr(`ACX_ADR_STEP3, 4'h3, 16'hFFFF);
            rd(`ACX_ADR_STEP3, 16'hE01F);
            seq_chk(1'b1, 1'b1);
            for (int g = 0; g < 4; g++) begin
                for (int p = 0; p < 16; p++) begin
                    c = {1'b0, 2'(g), 8'h00, 1'(p ^ g), 4'(p)};
                    wr(`ACX_ADR_STEP3, 4'h3, c);
                    chk_route(c);
                end
            end
            seq_chk(1'b1, 1'b0);
            $display("test field decode done");
            wr(`ACX_ADR_STEP4, 4'h3, 16'hFFFF);
            chk("step_four_config", 32'h0000_E01F, 32'(step4));
            rd(`ACX_ADR_STEP4, 16'hE01F);
            wr(12'h248, 4'hF, 16'h0000);
            rd(12'h248, 16'h0000);
            rd(`ACX_ADR_STEP4, 16'hE01F);
            wr(`ACX_ADR_STEP3, 4'h3, 16'hFFFF);
            wr(`ACX_ADR_STEP3, 4'h1, 16'h0000);
            rd(`ACX_ADR_STEP3, 16'hE000);
            $display("test step four, unmapped and lanes done");
        end
        stop_test();
    end
endmodule : acx_step_regs_tb
`default_nettype wire
